// >>> inc/pwi_consts.svh
`ifndef PWI_CONSTS_SVH
`define PWI_CONSTS_SVH
// ============================================================
// register map: address is {port[3:0], offset[11:0]}
`define PWI_OFS_WAKE_FLAGS   12'h013
`define PWI_OFS_WAKE_ENABLE  12'h017
`define PWI_OFS_IRQ_FLAGS    12'h01B
`define PWI_OFS_IRQ_MASK     12'h01F
`define PWI_OFS_EVT_STATUS   12'h0F0
`define PWI_OFS_EVT_MASK     12'h0F1
`define PWI_OFS_MAC_ADDR0    12'h0F8
// ============================================================
// field positions and reset values
`define PWI_BIT_MAGIC        2
`define PWI_BIT_LINK         1
`define PWI_BIT_ENERGY       0
`define PWI_BIT_PTP          2
`define PWI_BIT_XCVR         1
`define PWI_BIT_ACL          0
`define PWI_RST_BYTE         8'h00
`define PWI_RST_MASK         3'h0
`define PWI_FIRST_PORT       4'h1
`endif

// >>> inc/pwi_pkg.sv
package pwi_pkg;
    typedef logic [2:0] pwi_bits3_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic       wake;
        logic       irq;
    } pwi_out_t;
endpackage

// >>> inc/pwi_port_if.sv
`timescale 1ns/1ps
// per-port register view shared between top and the port slice
interface pwi_port_if;
    logic [2:0] wake_flags;
    logic [2:0] wake_en;
    logic [2:0] irq_flags;
    logic [2:0] irq_mask;
    logic       wr_flags;
    logic       wr_en;
    logic       wr_mask;
    logic [7:0] wdata;
    modport slice (output wake_flags, output wake_en, output irq_flags, output irq_mask,
                   input wr_flags, input wr_en, input wr_mask, input wdata);
    modport top   (input wake_flags, input wake_en, input irq_flags, input irq_mask,
                   output wr_flags, output wr_en, output wr_mask, output wdata);
endinterface

// >>> hw/pwi_port_slice.sv
`timescale 1ns/1ps
`include "pwi_consts.svh"
// one port's wake and interrupt registers
module pwi_port_slice #(
    parameter bit HAS_XCVR = 1'b1
) (
    input  wire logic      clk_sys_in,
    input  wire logic      nrst_in,
    input  wire logic      magic_hit_in,
    input  wire logic      link_up_in,
    input  wire logic      energy_in,
    input  wire logic      ptp_irq_in,
    input  wire logic      xcvr_irq_in,
    input  wire logic      acl_irq_in,
    pwi_port_if.slice      regs
);
    typedef struct packed {
        logic [2:0] wflg;
        logic [2:0] wen;
        logic       access_list_filter;
        logic [2:0] mask;
    } pwi_slice_st_t;

    pwi_slice_st_t st_q;
    pwi_slice_st_t st_d;
    logic [2:0]    ev;
    logic [2:0]    en_mask;

    // station port has no link or energy events
    assign en_mask = HAS_XCVR ? 3'h7 : 3'h4;
    assign ev      = {magic_hit_in, link_up_in, energy_in} & en_mask;

    // ============================================================
    // next state
    always_comb begin
        st_d = st_q;
        // write-one-to-clear, a new event in the same cycle wins
        if (regs.wr_flags) begin
            st_d.wflg = st_q.wflg & ~regs.wdata[2:0];
        end
        st_d.wflg = st_d.wflg | ev;
        if (regs.wr_en) begin
            st_d.wen = regs.wdata[2:0] & en_mask;
        end
        if (regs.wr_mask) begin
            st_d.mask = regs.wdata[2:0];
            // a toggle of the filter mask bit clears its status
            if (regs.wdata[`PWI_BIT_ACL] != st_q.mask[`PWI_BIT_ACL]) begin
                st_d.access_list_filter = 1'b0;
            end
        end
        if (acl_irq_in) begin
            st_d.access_list_filter = 1'b1;
        end
    end

    // ============================================================
    // state register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign regs.wake_flags = st_q.wflg;
    assign regs.wake_en    = st_q.wen;
    assign regs.irq_mask   = st_q.mask;
    // PTP and transceiver summaries are live levels, the filter bit is latched; all read-only
    assign regs.irq_flags  = {ptp_irq_in & HAS_XCVR, xcvr_irq_in & HAS_XCVR, st_q.access_list_filter};
endmodule // pwi_port_slice

// >>> hw/pwi_wake_irq.sv
`timescale 1ns/1ps
`include "pwi_consts.svh"
// per-port wake-event and interrupt-status block, three ports
module pwi_wake_irq #(
    parameter int NPORTS   = 3,
    parameter int NXCVR    = 2
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 nrst_in,
    input  wire logic [15:0]          addr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [7:0]           rdata_out,
    input  wire logic [NPORTS-1:0]    magic_seen_in,
    input  wire logic [NPORTS*48-1:0] magic_dest_in,
    input  wire logic [NPORTS-1:0]    link_up_in,
    input  wire logic [NPORTS-1:0]    energy_in,
    input  wire logic [NPORTS-1:0]    ptp_irq_in,
    input  wire logic [NPORTS-1:0]    xcvr_irq_in,
    input  wire logic [NPORTS-1:0]    acl_irq_in,
    output logic                      wake_event_pin_out,
    output logic                      irq_out
);
    // ============================================================
    // state
    typedef struct packed {
        logic [47:0]       mac;
        logic [NPORTS-1:0] link_s1;
        logic [NPORTS-1:0] link_s2;
        logic [NPORTS-1:0] link_s3;
        logic [NPORTS-1:0] en_s1;
        logic [NPORTS-1:0] en_s2;
        logic [NPORTS-1:0] en_s3;
        logic [NPORTS-1:0] evst;
        logic [NPORTS-1:0] evmask;
        logic [NPORTS-1:0] ppend;
        pwi_pkg::pwi_out_t o;
    } pwi_top_st_t;

    pwi_top_st_t       st_q;
    pwi_top_st_t       st_d;
    logic [NPORTS-1:0] magic_hit;
    logic [NPORTS-1:0] wake_any;
    logic [NPORTS-1:0] irq_any;
    logic [NPORTS-1:0] sel;
    logic [11:0]       ofs;
    logic [7:0]        rd_mux;
    logic [7:0]        port_rd [NPORTS];

    pwi_port_if pif [NPORTS] ();

    assign ofs = addr_in[11:0];

    // port field of the address selects a slice
    function automatic logic port_hit(input logic [15:0] a, input int p);
        port_hit = (a[15:12] == (`PWI_FIRST_PORT + 4'(p)));
    endfunction

    // one port's register byte at an offset, unmapped offsets read zero
    function automatic logic [7:0] port_byte(
        input logic [11:0] o,
        input logic [2:0]  wf,
        input logic [2:0]  we,
        input logic [2:0]  fl,
        input logic [2:0]  mk
    );
        case (o)
            `PWI_OFS_WAKE_FLAGS:  port_byte = {5'h00, wf};
            `PWI_OFS_WAKE_ENABLE: port_byte = {5'h00, we};
            `PWI_OFS_IRQ_FLAGS:   port_byte = {5'h00, fl};
            `PWI_OFS_IRQ_MASK:    port_byte = {5'h00, mk};
            default:              port_byte = 8'h00;
        endcase
    endfunction

    // ============================================================
    // per-port slices
    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : g_port
            // link and energy come off the copper side, another clock
            logic link_rise;
            logic en_rise;
            assign link_rise = st_q.link_s2[g] & ~st_q.link_s3[g];
            assign en_rise   = st_q.en_s2[g] & ~st_q.en_s3[g];
            // destination compared against the station address
            assign magic_hit[g] = magic_seen_in[g]
                & (magic_dest_in[g*48 +: 48] == st_q.mac);
            assign sel[g] = port_hit(addr_in, g);
            assign pif[g].wr_flags = wr_in & sel[g] & (ofs == `PWI_OFS_WAKE_FLAGS);
            assign pif[g].wr_en    = wr_in & sel[g] & (ofs == `PWI_OFS_WAKE_ENABLE);
            assign pif[g].wr_mask  = wr_in & sel[g] & (ofs == `PWI_OFS_IRQ_MASK);
            assign pif[g].wdata    = wdata_in;
            // interface arrays take constant indices only, so each byte is built here
            assign port_rd[g] = port_byte(ofs, pif[g].wake_flags, pif[g].wake_en,
                                          pif[g].irq_flags, pif[g].irq_mask);
            pwi_port_slice #(
                .HAS_XCVR (g < NXCVR)
            ) u_slice (
                .clk_sys_in   (clk_sys_in),
                .nrst_in      (nrst_in),
                .magic_hit_in (magic_hit[g]),
                .link_up_in   (link_rise),
                .energy_in    (en_rise),
                .ptp_irq_in   (ptp_irq_in[g]),
                .xcvr_irq_in  (xcvr_irq_in[g]),
                .acl_irq_in   (acl_irq_in[g]),
                .regs         (pif[g])
            );
            // enabled latched wake flags
            assign wake_any[g] = |(pif[g].wake_flags & pif[g].wake_en);
            // mask bit zero enables its source
            assign irq_any[g]  = |(pif[g].irq_flags & ~pif[g].irq_mask);
        end
    endgenerate

    // ============================================================
    // read mux, unmapped reads return zero
    always_comb begin
        rd_mux = 8'h00;
        for (int p = 0; p < NPORTS; p++) begin
            if (sel[p]) begin
                rd_mux = port_rd[p];
            end
        end
        if (addr_in[15:12] == 4'h0) begin
            if (ofs == `PWI_OFS_EVT_STATUS) begin
                rd_mux = 8'(st_q.evst);
            end else if (ofs == `PWI_OFS_EVT_MASK) begin
                rd_mux = 8'(st_q.evmask);
            end else if (ofs >= `PWI_OFS_MAC_ADDR0 && ofs < `PWI_OFS_MAC_ADDR0 + 12'h006) begin
                rd_mux = st_q.mac[8*(5 - 32'(ofs - `PWI_OFS_MAC_ADDR0)) +: 8];
            end
        end
    end

    // ============================================================
    // next state
    always_comb begin
        st_d = st_q;
        // two-flop synchronisers, third flop for edge detect
        st_d.link_s1 = link_up_in;
        st_d.link_s2 = st_q.link_s1;
        st_d.link_s3 = st_q.link_s2;
        st_d.en_s1   = energy_in;
        st_d.en_s2   = st_q.en_s1;
        st_d.en_s3   = st_q.en_s2;
        // station address bytes, byte 0 is the most significant
        if (wr_in && addr_in[15:12] == 4'h0) begin
            for (int b = 0; b < 6; b++) begin
                if (ofs == `PWI_OFS_MAC_ADDR0 + 12'(b)) begin
                    st_d.mac[8*(5-b) +: 8] = wdata_in;
                end
            end
            if (ofs == `PWI_OFS_EVT_MASK) begin
                st_d.evmask = wdata_in[NPORTS-1:0];
            end
        end
        // sticky event status: read clears, new rise wins
        if (rd_in && addr_in[15:12] == 4'h0 && ofs == `PWI_OFS_EVT_STATUS) begin
            st_d.evst = '0;
        end
        st_d.evst  = st_d.evst | (irq_any & ~st_q.ppend);
        st_d.ppend = irq_any;
        st_d.o.rdata = rd_in ? rd_mux : 8'h00;
        st_d.o.wake  = |wake_any;
        st_d.o.irq   = |(st_d.evst & ~st_d.evmask);
    end

    // ============================================================
    // state register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_out          = st_q.o.rdata;
    assign wake_event_pin_out = st_q.o.wake;
    assign irq_out            = st_q.o.irq;
endmodule // pwi_wake_irq

// >>> dv/pwi_wake_irq_chk.sv
`timescale 1ns/1ps
// ============================================================
// port checks on the register read path and the two level outputs
module pwi_wake_irq_chk (
    input wire logic        clk_sys_in,
    input wire logic        nrst_in,
    input wire logic [15:0] addr_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        wake_event_pin_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    // ============================================================
    // read data
    AST_RD_IDLE_ZERO: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    AST_FLAGS_RSVD: assert property (rd_in && addr_in[11:0] == 12'h013 |=> rdata_out[7:3] == 5'h00)
        else $error("wake flag reserved bits set");
    AST_STAT_RSVD: assert property (rd_in && addr_in[11:0] == 12'h01B |=> rdata_out[7:3] == 5'h00)
        else $error("status reserved bits set");
    AST_MASK_RSVD: assert property (rd_in && addr_in[11:0] == 12'h01F |=> rdata_out[7:3] == 5'h00)
        else $error("mask reserved bits set");
    AST_P3_NO_LINK: assert property (rd_in && addr_in == 16'h3013 |=> rdata_out[1:0] == 2'h0)
        else $error("station port shows link or energy");
    AST_P3_NO_XCVR: assert property (rd_in && addr_in == 16'h301B |=> rdata_out[2:1] == 2'h0)
        else $error("station port shows transceiver status");
    // ============================================================
    // outputs drop only in answer to software, within two cycles
    AST_WAKE_FALL: assert property ($fell(wake_event_pin_out) |-> $past(wr_in) || $past(wr_in, 2))
        else $error("wake pin fell without a write");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_in | rd_in) || $past(wr_in | rd_in, 2))
        else $error("interrupt fell without an access");
    COV_WAKE: cover property ($rose(wake_event_pin_out));
    COV_IRQ: cover property ($rose(irq_out));
    COV_P3: cover property (rd_in && addr_in == 16'h301B);
endmodule // pwi_wake_irq_chk

bind pwi_wake_irq pwi_wake_irq_chk u_chk (.clk_sys_in, .nrst_in, .addr_in, .wr_in, .rd_in,
    .rdata_out, .wake_event_pin_out, .irq_out);

// >>> dv/test_pwi_wake_irq.sv
`timescale 1ns/1ps
module test_pwi_wake_irq;
    logic         clk_sys_in = 1'b0;
    logic         nrst_in = 1'b0;
    logic [15:0]  addr_in = 16'h0000;
    logic [7:0]   wdata_in = 8'h00;
    logic         wr_in = 1'b0;
    logic         rd_in = 1'b0;
    logic [7:0]   rdata_out;
    logic [2:0]   magic_seen_in = 3'h0, link_up_in = 3'h0, energy_in = 3'h0;
    logic [2:0]   ptp_irq_in = 3'h0, xcvr_irq_in = 3'h0, acl_irq_in = 3'h0;
    logic [143:0] magic_dest_in = 144'h0;
    logic         wake_event_pin_out, irq_out, rd_q = 1'b0;
    logic [47:0]  sta;
    logic [7:0]   exp_q[$];
    int           error_cnt = 0, check_count = 0, seed = 32'h39DC6A6D;
    pwi_wake_irq DUT (.clk_sys_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .magic_seen_in, .magic_dest_in, .link_up_in, .energy_in, .ptp_irq_in, .xcvr_irq_in,
        .acl_irq_in, .wake_event_pin_out, .irq_out);
    always #2.5 clk_sys_in = ~clk_sys_in;
    // ============================================================
    // shared tasks
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one bus cycle; strobes stay up across back-to-back calls
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
    endtask
    task automatic cyc(input int n);
        repeat (n) bus(1'b0, 1'b0, 16'h0000, 8'h00);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic pins(input logic wake, input logic irq);
        #1;
        chk("wake", {7'h00, wake_event_pin_out}, {7'h00, wake});
        chk("irq", {7'h00, irq_out}, {7'h00, irq});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ============================================================
    // monitor: read data stands in the cycle after the strobe only
    always @(posedge clk_sys_in) rd_q <= rd_in;
    always @(negedge clk_sys_in) begin
        if (rd_q) begin
            if (exp_q.size() == 0) error_cnt++;
            else chk("rdata", rdata_out, exp_q.pop_front());
        end
    end
    // hang guard, far above the sequence length
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        error_cnt++;
        finish_test;
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int p = 1; p <= 3; p++) begin
            for (int i = 0; i < 4; i++) rd({p[3:0], 12'h013 + 12'(i * 4)}, 8'h00);
        end
        rd(16'h1020, 8'h00);
        $display("test reset done");
        sta = 48'({$random(seed), $random(seed)});
        for (int i = 0; i < 6; i++) bus(1'b1, 1'b0, 16'h00F8 + 16'(i), sta[47 - 8 * i -: 8]);
        magic_dest_in <= {sta, sta ^ 48'h1, sta};
        magic_seen_in <= 3'h7;
        cyc(1);
        magic_seen_in <= 3'h0;
        cyc(2);
        rd(16'h1013, 8'h04);
        rd(16'h2013, 8'h00);
        rd(16'h3013, 8'h04);
        cyc(2);
        pins(1'b0, 1'b0);
        bus(1'b1, 1'b0, 16'h1017, 8'h07);
        bus(1'b1, 1'b0, 16'h3017, 8'h07);
        cyc(2);
        pins(1'b1, 1'b0);
        rd(16'h1017, 8'h07);
        rd(16'h3017, 8'h04);
        bus(1'b1, 1'b0, 16'h1013, 8'h04);
        bus(1'b1, 1'b0, 16'h3013, 8'hFF);
        cyc(2);
        pins(1'b0, 1'b0);
        rd(16'h1013, 8'h00);
        $display("test magic done");
        link_up_in <= 3'h5;
        cyc(7);
        rd(16'h1013, 8'h02);
        rd(16'h3013, 8'h00);
        pins(1'b1, 1'b0);
        bus(1'b1, 1'b0, 16'h1017, 8'h04);
        cyc(2);
        pins(1'b0, 1'b0);
        energy_in <= 3'h1;
        cyc(7);
        rd(16'h1013, 8'h03);
        cyc(2);
        pins(1'b0, 1'b0);
        bus(1'b1, 1'b0, 16'h1017, 8'h01);
        cyc(2);
        pins(1'b1, 1'b0);
        bus(1'b1, 1'b0, 16'h1013, 8'hFF);
        cyc(2);
        pins(1'b0, 1'b0);
        $display("test link done");
        bus(1'b1, 1'b0, 16'h00F1, 8'h01);
        ptp_irq_in <= 3'h5;
        xcvr_irq_in <= 3'h5;
        cyc(4);
        pins(1'b0, 1'b0);
        rd(16'h00F1, 8'h01);
        bus(1'b1, 1'b0, 16'h00F1, 8'h00);
        cyc(1);
        pins(1'b0, 1'b1);
        rd(16'h101B, 8'h06);
        rd(16'h301B, 8'h00);
        rd(16'h00F0, 8'h01);
        ptp_irq_in <= 3'h0;
        xcvr_irq_in <= 3'h0;
        cyc(3);
        pins(1'b0, 1'b0);
        acl_irq_in <= 3'h2;
        cyc(1);
        acl_irq_in <= 3'h0;
        cyc(3);
        rd(16'h201B, 8'h01);
        bus(1'b1, 1'b0, 16'h201B, 8'h00);
        rd(16'h201B, 8'h01);
        bus(1'b1, 1'b0, 16'h201F, 8'h01);
        rd(16'h201B, 8'h00);
        rd(16'h201F, 8'h01);
        rd(16'h00F0, 8'h02);
        acl_irq_in <= 3'h2;
        cyc(1);
        acl_irq_in <= 3'h0;
        cyc(3);
        rd(16'h00F0, 8'h00);
        cyc(2);
        pins(1'b0, 1'b0);
        $display("test irq done");
        finish_test;
    end
endmodule // test_pwi_wake_irq
